// ### core/overflow_trap_return_branch_exec.sv
// overflow trap, interrupt return and short carry/zero jumps behind an AXI4-Lite slave
// Notes on behaviour
// - overflow trap with overflow flag clear just continues, no interrupt entered
// - overflow trap with overflow flag set raises type 4 through vector 10H
// - trap: stack pointer minus two, push flags, clear trap/enable, push segment, pointer
// - after pushes, segment loads from word 12H and pointer from word 10H
// - interrupt return pops pointer, segment, flags, stack pointer plus two each
// - interrupt return restores every flag from the popped word
// - interrupt return behaves the same for hardware and software entry
// - taken short jump adds sign-extended 8-bit displacement to the pointer
// - above jump taken when carry clear or zero clear
// - above-or-equal jump taken exactly when carry is clear
// - below jump taken exactly when carry is set
// - below-or-equal jump taken when carry set or zero set
// - jump on carry taken exactly when carry is set
// - jumps and trap leave flags alone except trap/enable clear on trap
// - pushed flags word uses the push-flags bit layout
`timescale 1ns/10ps
`include "ovf_exec_params.svh"
module overflow_trap_return_branch_exec
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic memReq,
   output logic memWe,
   output logic [15:0] memAddr,
   output logic [15:0] memWdata,
   input wire logic memAck,
   input wire logic [15:0] memRdata,
   output logic irq
);
   import ovf_exec_pkg::*;

   // ==========================================
   // state
   state_e stQ, stD;
   logic [15:0] fQ, fD, ptrQ, ptrD, csQ, csD, stkQ, stkD;
   logic [15:0] memAddrQ, memAddrD, memWdataQ, memWdataD;
   logic memReqQ, memReqD, memWeQ, memWeD;
   logic [1:0] statQ, statD, maskQ, maskD;
   logic bvalidQ, rvalidQ;
   logic [1:0] brespQ, rrespQ;
   logic [31:0] rdataQ;
   logic evDone, evTrap;

   // ==========================================
   // bus decode
   wire busy = (stQ != S_IDLE);
   wire wrFire = awvalid && wvalid && !bvalidQ;
   wire rdFire = arvalid && !rvalidQ;
   // word writes only; a write with strobe bit 0 set lands whole, one without it is dropped; low half holds all data
   wire wrLow = wrFire && wstrb[0];
   wire wCmd = wrLow && awaddr == `OFS_CMD;
   wire wFlags = wrLow && awaddr == `OFS_FLAGS;
   wire wPtr = wrLow && awaddr == `OFS_PTR;
   wire wCs = wrLow && awaddr == `OFS_CS;
   wire wStk = wrLow && awaddr == `OFS_STK;
   wire wStat = wrLow && awaddr == `OFS_STATUS;
   wire wMask = wrLow && awaddr == `OFS_MASK;
   wire wrKnown = awaddr <= `OFS_MASK && awaddr[1:0] == 2'b00;
   wire rdKnown = araddr <= `OFS_MASK && araddr[1:0] == 2'b00;
   wire [3:0] cmdOp = wdata[3:0];
   wire [15:0] sext = {{8{wdata[15]}}, wdata[15:8]};
   wire launch = wCmd && !busy;
   wire launchTrap = launch && cmdOp == OP_OVF_TRAP;
   wire launchJump = launch && cmdOp != OP_OVF_TRAP && cmdOp != OP_INT_RETURN;
   wire taken = jumpTaken(cmdOp, fQ[`BIT_CARRY], fQ[`BIT_ZERO]);
   wire [15:0] stkDown = stkQ - `STACK_STEP;
   wire [15:0] stkUp = stkQ + `STACK_STEP;
   wire [15:0] statusWord = {7'h00, busy, 6'h00, statQ};
   wire [15:0] rdMux = (araddr == `OFS_FLAGS) ? fQ :
                       (araddr == `OFS_PTR) ? ptrQ :
                       (araddr == `OFS_CS) ? csQ :
                       (araddr == `OFS_STK) ? stkQ :
                       (araddr == `OFS_STATUS) ? statusWord :
                       (araddr == `OFS_MASK) ? {14'h0000, maskQ} : 16'h0000;

   assign awready = wvalid && !bvalidQ;
   assign wready = awvalid && !bvalidQ;
   assign arready = !rvalidQ;
   assign bvalid = bvalidQ;
   assign bresp = brespQ;
   assign rvalid = rvalidQ;
   assign rresp = rrespQ;
   assign rdata = rdataQ;
   assign memReq = memReqQ;
   assign memWe = memWeQ;
   assign memAddr = memAddrQ;
   assign memWdata = memWdataQ;
   assign irq = |(statQ & maskQ);

   // ==========================================
   // execution sequencer
   always_comb
   begin
      stD = stQ;
      fD = fQ;
      ptrD = ptrQ;
      csD = csQ;
      stkD = stkQ;
      memReqD = memReqQ;
      memWeD = memWeQ;
      memAddrD = memAddrQ;
      memWdataD = memWdataQ;
      evDone = 1'b0;
      evTrap = 1'b0;
      if (!busy)
      begin
         // machine state only writable while idle, else a step would be torn
         if (wFlags)
            fD = wdata[15:0] & `FLAG_MASK;
         if (wPtr)
            ptrD = wdata[15:0];
         if (wCs)
            csD = wdata[15:0];
         if (wStk)
            stkD = wdata[15:0];
         if (launch)
         begin
            case (cmdOp)
               OP_OVF_TRAP:
               begin
                  if (fQ[`BIT_OVF])
                  begin
                     stkD = stkDown;
                     memReqD = 1'b1;
                     memWeD = 1'b1;
                     memAddrD = stkDown;
                     memWdataD = fQ;
                     stD = S_PUSHF;
                  end
                  else
                     evDone = 1'b1;
               end
               OP_INT_RETURN:
               begin
                  memReqD = 1'b1;
                  memWeD = 1'b0;
                  memAddrD = stkQ;
                  stD = S_POPIP;
               end
               default:
               begin
                  if (taken)
                     ptrD = ptrQ + sext;
                  evDone = 1'b1;
               end
            endcase
         end
      end
      else if (memAck)
      begin
         case (stQ)
            S_PUSHF:
            begin
               fD[`BIT_TRAP] = 1'b0;
               fD[`BIT_IF] = 1'b0;
               stkD = stkDown;
               memAddrD = stkDown;
               memWdataD = csQ;
               stD = S_PUSHCS;
            end
            S_PUSHCS:
            begin
               stkD = stkDown;
               memAddrD = stkDown;
               memWdataD = ptrQ;
               stD = S_PUSHIP;
            end
            S_PUSHIP:
            begin
               memWeD = 1'b0;
               memAddrD = `VEC_CS_ADDR;
               stD = S_LDCS;
            end
            S_LDCS:
            begin
               csD = memRdata;
               memAddrD = `VEC_IP_ADDR;
               stD = S_LDIP;
            end
            S_LDIP:
            begin
               ptrD = memRdata;
               memReqD = 1'b0;
               evDone = 1'b1;
               evTrap = 1'b1;
               stD = S_IDLE;
            end
            S_POPIP:
            begin
               ptrD = memRdata;
               stkD = stkUp;
               memAddrD = stkUp;
               stD = S_POPCS;
            end
            S_POPCS:
            begin
               csD = memRdata;
               stkD = stkUp;
               memAddrD = stkUp;
               stD = S_POPF;
            end
            S_POPF:
            begin
               fD = memRdata & `FLAG_MASK;
               stkD = stkUp;
               memReqD = 1'b0;
               evDone = 1'b1;
               stD = S_IDLE;
            end
            default:
            begin
               memReqD = 1'b0;
               stD = S_IDLE;
            end
         endcase
      end
   end

   // ==========================================
   // event status and mask; an event beats a same-cycle clear
   always_comb
   begin
      statD = statQ & ~(wStat ? wdata[1:0] : 2'b00);
      statD[`EVT_DONE] = statD[`EVT_DONE] | evDone;
      statD[`EVT_TRAP] = statD[`EVT_TRAP] | evTrap;
      maskD = wMask ? wdata[1:0] : maskQ;
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stQ <= S_IDLE;
         fQ <= `RST_WORD;
         ptrQ <= `RST_WORD;
         csQ <= `RST_WORD;
         stkQ <= `RST_WORD;
         memReqQ <= 1'b0;
         memWeQ <= 1'b0;
         memAddrQ <= `RST_WORD;
         memWdataQ <= `RST_WORD;
         statQ <= `RST_EVT;
         maskQ <= `RST_EVT;
      end
      else
      begin
         stQ <= stD;
         fQ <= fD;
         ptrQ <= ptrD;
         csQ <= csD;
         stkQ <= stkD;
         memReqQ <= memReqD;
         memWeQ <= memWeD;
         memAddrQ <= memAddrD;
         memWdataQ <= memWdataD;
         statQ <= statD;
         maskQ <= maskD;
      end
   end

   // ==========================================
   // bus responses
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bvalidQ <= 1'b0;
         brespQ <= 2'b00;
         rvalidQ <= 1'b0;
         rrespQ <= 2'b00;
         rdataQ <= 32'h0000_0000;
      end
      else
      begin
         if (wrFire)
         begin
            bvalidQ <= 1'b1;
            brespQ <= wrKnown ? 2'b00 : 2'b10;
         end
         else if (bready)
            bvalidQ <= 1'b0;
         if (rdFire)
         begin
            rvalidQ <= 1'b1;
            rrespQ <= rdKnown ? 2'b00 : 2'b10;
            rdataQ <= {16'h0000, rdMux};
         end
         else if (rready)
            rvalidQ <= 1'b0;
      end
   end

   // ==========================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence trapStart;
      launchTrap && fQ[`BIT_OVF];
   endsequence
   sequence ackIn(state_e s);
      stQ == s && memAck;
   endsequence

   noTrapClear_a: assert property (launchTrap && !fQ[`BIT_OVF] |=> stQ == S_IDLE && !memReqQ && $stable(ptrQ))
      else $error("trap entered with overflow clear");
   flagsPush_a: assert property (trapStart |=> memWeQ && memAddrQ == $past(stkQ) - `STACK_STEP &&
      memWdataQ == $past(fQ))
      else $error("flags push wrong");
   flagClear_a: assert property (ackIn(S_PUSHF) |=> !fQ[`BIT_TRAP] && !fQ[`BIT_IF] && memWdataQ == csQ)
      else $error("trap or enable flag not cleared");
   segVector_a: assert property (ackIn(S_PUSHIP) |=> memAddrQ == `VEC_CS_ADDR && !memWeQ && memReqQ)
      else $error("segment vector address wrong");
   ipVector_a: assert property (ackIn(S_LDCS) |=> memAddrQ == `VEC_IP_ADDR && csQ == $past(memRdata))
      else $error("pointer vector address wrong");
   popOrder_a: assert property (ackIn(S_POPIP) |=> stQ == S_POPCS && stkQ == $past(stkQ) + `STACK_STEP)
      else $error("pop order or stack step wrong");
   popFlags_a: assert property (ackIn(S_POPF) |=> fQ == ($past(memRdata) & `FLAG_MASK) && stQ == S_IDLE)
      else $error("flags not restored");
   jumpAdd_a: assert property (launchJump && taken |=> ptrQ == $past(ptrQ) + $past(sext))
      else $error("taken jump target wrong");
   jumpHold_a: assert property (launchJump && !taken |=> $stable(ptrQ))
      else $error("untaken jump moved pointer");
   jumpFlags_a: assert property (launchJump |=> $stable(fQ) && statQ[`EVT_DONE])
      else $error("jump changed flags");
endmodule : overflow_trap_return_branch_exec

// ### common/ovf_exec_params.svh
// offsets, reset values, vector addresses and flag positions of the execution block
`ifndef OVF_EXEC_PARAMS_SVH
`define OVF_EXEC_PARAMS_SVH
// ==========================================
// register byte offsets
`define OFS_CMD 8'h00
`define OFS_FLAGS 8'h04
`define OFS_PTR 8'h08
`define OFS_CS 8'h0c
`define OFS_STK 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASK 8'h18
// ==========================================
// reset values
`define RST_WORD 16'h0000
`define RST_EVT 2'h0
// ==========================================
// overflow vector and stack step
`define VEC_IP_ADDR 16'h0010
`define VEC_CS_ADDR 16'h0012
`define STACK_STEP 16'h0002
// ==========================================
// flag bit positions, push-flags layout
`define FLAG_MASK 16'h0fd5
`define BIT_CARRY 0
`define BIT_ZERO 6
`define BIT_TRAP 8
`define BIT_IF 9
`define BIT_OVF 11
// ==========================================
// status bits
`define EVT_DONE 0
`define EVT_TRAP 1
`define BIT_BUSY 8
`endif

// ### common/ovf_exec_pkg.sv
// types and condition decode for the execution block
package ovf_exec_pkg;
   typedef enum logic [3:0]
   {
      OP_OVF_TRAP = 4'h0,
      OP_INT_RETURN = 4'h1,
      OP_JUMP_ABOVE = 4'h2,
      OP_JUMP_ABOVE_EQ = 4'h3,
      OP_JUMP_BELOW = 4'h4,
      OP_JUMP_BELOW_EQ = 4'h5,
      OP_JUMP_CARRY = 4'h6
   } op_e;

   typedef enum logic [3:0]
   {
      S_IDLE = 4'h0,
      S_PUSHF = 4'h1,
      S_PUSHCS = 4'h2,
      S_PUSHIP = 4'h3,
      S_LDCS = 4'h4,
      S_LDIP = 4'h5,
      S_POPIP = 4'h6,
      S_POPCS = 4'h7,
      S_POPF = 4'h8
   } state_e;

   // aliases keep separate codes; below and carry decode alike
   function automatic logic jumpTaken(input logic [3:0] op, input logic carry, input logic zero);
      case (op)
         OP_JUMP_ABOVE: jumpTaken = !carry || !zero;
         OP_JUMP_ABOVE_EQ: jumpTaken = !carry;
         OP_JUMP_BELOW: jumpTaken = carry;
         OP_JUMP_BELOW_EQ: jumpTaken = carry || zero;
         OP_JUMP_CARRY: jumpTaken = carry;
         default: jumpTaken = 1'b0;
      endcase
   endfunction : jumpTaken
endpackage : ovf_exec_pkg

// ### dv/stack_memory_model.sv
// stack and vector memory seen by the execution block
`timescale 1ns/10ps
`include "ovf_exec_params.svh"
module stack_memory_model
#(
   parameter logic [15:0] VOFF = 16'h0200,
   parameter logic [15:0] VSEG = 16'h0300
)
(
   input wire logic clk,
   input wire logic memReq,
   input wire logic memWe,
   input wire logic [15:0] memAddr,
   input wire logic [15:0] memWdata,
   input wire logic [3:0] lat,
   output logic memAck,
   output logic [15:0] memRdata
);
   logic [15:0] m [0:255];
   logic [3:0] cnt;
   logic [15:0] junk;
   // ==========
   // vectors present before any trap
   initial
   begin
      m[`VEC_IP_ADDR >> 1] = VOFF;
      m[`VEC_CS_ADDR >> 1] = VSEG;
      memAck = 1'b0;
      cnt = 4'h0;
      junk = 16'h5a3c;
   end
   // ==========
   // lat idle cycles before each ack; bus churns when not answering
   always @(posedge clk)
   begin
      junk <= {junk[14:0], ~junk[15]};
      memAck <= 1'b0;
      if (memReq && !memAck)
      begin
         cnt <= (cnt == lat) ? 4'h0 : cnt + 4'h1;
         memAck <= (cnt == lat);
         if (cnt == lat && memWe)
            m[memAddr[8:1]] <= memWdata;
      end
   end
   assign memRdata = memAck ? m[memAddr[8:1]] : junk;
endmodule : stack_memory_model

// ### dv/overflow_trap_return_branch_exec_bench.sv
// self-checking bench for the trap, return and jump block
`timescale 1ns/10ps
`include "ovf_exec_params.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t %h %h", $time, a, e); end end
module overflow_trap_return_branch_exec_bench;
   import ovf_exec_pkg::*;
   localparam logic [15:0] VOFF = 16'h2468;
   localparam logic [15:0] VSEG = 16'h1357;
   logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, arvalid = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic [3:0] lat = 0;
   logic awready, wready, bvalid, arready, rvalid, memReq, memWe, memAck, irq;
   logic [1:0] bresp, rresp;
   logic [15:0] memAddr, memWdata, memRdata, ptr, fl, e, x = 16'd65;
   logic [33:0] rq[$], rExp;
   logic [1:0] bq[$], bExp;
   int fails = 0, n_checks = 0;
   overflow_trap_return_branch_exec uut (.clk(clk), .sys_rst(rst), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(1'b1), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
      .memWdata(memWdata), .memAck(memAck), .memRdata(memRdata), .irq(irq));
   stack_memory_model #(.VOFF(VOFF), .VSEG(VSEG)) mem (.clk(clk), .memReq(memReq), .memWe(memWe),
      .memAddr(memAddr), .memWdata(memWdata), .lat(lat), .memAck(memAck), .memRdata(memRdata));
   always #25 clk = ~clk;
   // ==========
   // helpers
   function automatic logic [15:0] rnd();
      x ^= x << 7;
      x ^= x >> 9;
      x ^= x << 8;
      return x;
   endfunction : rnd
   function automatic logic tk(input int op, input logic c, input logic z);
      case (op)
         2: return !c || !z;
         3: return !c;
         4, 6: return c;
         5: return c || z;
         default: return 1'b0;
      endcase
   endfunction : tk
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'b00);
      bq.push_back(r);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge clk); while (!(awready && wready));
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge clk); while (!bvalid);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] r = 2'b00);
      rq.push_back({r, 16'h0000, d});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
   endtask : rd
   task automatic waitIrq();
      repeat (300) if (!irq) @(posedge clk);
      `CHK(irq, 1'b1)
   endtask : waitIrq
   task automatic results();
      if (fails == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : results
   // ==========
   // response watcher pops the oldest note
   always @(posedge clk)
   begin
      // pop once, the report line would otherwise pop again
      if (bvalid)
      begin
         bExp = bq.pop_front();
         `CHK(bresp, bExp)
      end
      if (rvalid)
      begin
         rExp = rq.pop_front();
         `CHK({rresp, rdata}, rExp)
      end
   end
   initial
   begin
      #2000000;
      fails++;
      results();
   end
   // ==========
   // scenarios
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 4; a < 'h1c; a += 4)
         rd(a[7:0], `RST_WORD);
      rd(8'h1c, 16'h0000, 2'b10);
      wr(8'h1c, 16'h0000, 2'b10);
      for (int op = 2; op < 8; op++)
         for (int c = 0; c < 4; c++)
         begin
            fl = rnd() & `FLAG_MASK & ~16'h0041 | {9'h0, c[1], 5'h0, c[0]};
            ptr = rnd();
            e = rnd();
            wr(`OFS_FLAGS, fl);
            wr(`OFS_PTR, ptr);
            wr(`OFS_CMD, {e[7:0], 4'h0, op[3:0]});
            if (tk(op, c[0], c[1]))
               ptr += {{8{e[7]}}, e[7:0]};
            rd(`OFS_PTR, ptr);
            rd(`OFS_FLAGS, fl);
         end
      wr(`OFS_STK, 16'h0100);
      wr(`OFS_CS, 16'h1234);
      wr(`OFS_FLAGS, 16'h0301);
      wr(`OFS_MASK, 16'h0002);
      // done is still set from the jumps; clear it so this trap must set it
      wr(`OFS_STATUS, 16'h0003);
      wr(`OFS_CMD, 16'h0000);
      rd(`OFS_PTR, ptr);
      rd(`OFS_STK, 16'h0100);
      rd(`OFS_STATUS, 16'h0001);
      rd(`OFS_FLAGS, 16'h0301);
      `CHK(irq, 1'b0)
      // slow memory so every push waits on ack
      lat <= 4'd3;
      fl = 16'h0b01;
      wr(`OFS_FLAGS, fl);
      wr(`OFS_CMD, 16'h0000);
      waitIrq();
      `CHK(mem.m[8'h7f], fl)
      `CHK(mem.m[8'h7e], 16'h1234)
      `CHK(mem.m[8'h7d], ptr)
      rd(`OFS_CS, VSEG);
      rd(`OFS_PTR, VOFF);
      rd(`OFS_STK, 16'h00fa);
      rd(`OFS_FLAGS, 16'h0801);
      rd(`OFS_STATUS, 16'h0003);
      wr(`OFS_STATUS, 16'h0003);
      `CHK(irq, 1'b0)
      wr(`OFS_MASK, 16'h0001);
      wr(`OFS_CMD, 16'h0001);
      waitIrq();
      rd(`OFS_PTR, ptr);
      rd(`OFS_CS, 16'h1234);
      rd(`OFS_FLAGS, fl);
      rd(`OFS_STK, 16'h0100);
      // frame laid down as a hardware entry would leave it
      lat <= 4'd0;
      wr(`OFS_STATUS, 16'h0003);
      mem.m[8'h80] = 16'h0abc;
      mem.m[8'h81] = 16'h4321;
      mem.m[8'h82] = 16'hffff;
      wr(`OFS_CMD, 16'h0001);
      waitIrq();
      wr(`OFS_MASK, 16'h0000);
      `CHK(irq, 1'b0)
      rd(`OFS_STATUS, 16'h0001);
      rd(`OFS_FLAGS, `FLAG_MASK);
      rd(`OFS_CS, 16'h4321);
      rd(`OFS_PTR, 16'h0abc);
      rd(`OFS_STK, 16'h0106);
      results();
   end
endmodule : overflow_trap_return_branch_exec_bench
